/* dll_seq_pkg.sv */
package dll_seq_pkg;

  // ==========================================================
  // Clock and timing figures.
  localparam int TCK_PS        = 8000;
  localparam int TCKSRE_NS     = 10;
  localparam int TCKSRE_NCK    = 5;
  localparam int TCKSRX_NS     = 10;
  localparam int TCKSRX_NCK    = 5;
  localparam int TXS_NS        = 170;
  localparam int TXS_NCK       = 5;
  localparam int TMOD_NS       = 15;
  localparam int TMOD_NCK      = 12;
  localparam int TMRD_NCK      = 4;
  localparam int TDLLK_NCK     = 512;
  localparam int TZQOPER_NCK   = 512;
  localparam int PS_PER_NS     = 1000;

  // Nanoseconds to whole cycles, rounded up, never below the cycle minimum.
  function automatic int ns_to_cyc(input int ns, input int nck_min);
    int c;
    c = (ns * PS_PER_NS + TCK_PS - 1) / TCK_PS;
    return (c < nck_min) ? nck_min : c;
  endfunction : ns_to_cyc

  localparam int CKSRE_CYC  = ns_to_cyc(TCKSRE_NS, TCKSRE_NCK);
  localparam int CKSRX_CYC  = ns_to_cyc(TCKSRX_NS, TCKSRX_NCK);
  localparam int XS_CYC     = ns_to_cyc(TXS_NS, TXS_NCK);
  localparam int MOD_CYC    = ns_to_cyc(TMOD_NS, TMOD_NCK);
  localparam int MRD_CYC    = TMRD_NCK;

  // ==========================================================
  // Command bus encodings as {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] CMD_DES = 4'hf;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_ZQ  = 4'h6;

  // ==========================================================
  // Mode register selects and address bits.
  localparam logic [2:0] BA_MR0      = 3'h0;
  localparam logic [2:0] BA_MR1      = 3'h1;
  localparam logic [2:0] BA_MR2      = 3'h2;
  localparam int         BIT_DLL_OFF = 0;
  localparam int         BIT_DLL_RST = 8;
  localparam int         BIT_ZQ_LONG = 10;
  localparam int         ADDR_W      = 16;
  localparam int         TMR_W       = 10;

  // ==========================================================
  // Sequence states.
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h00,
    ST_SRE     = 5'h01,
    ST_W_CKSRE = 5'h02,
    ST_W_CLK   = 5'h03,
    ST_W_CKSRX = 5'h04,
    ST_SRX     = 5'h05,
    ST_W_XS    = 5'h06,
    ST_DLL_ON  = 5'h07,
    ST_W_MRD1  = 5'h08,
    ST_DLL_RST = 5'h09,
    ST_W_MRD2  = 5'h0a,
    ST_UPD2    = 5'h0b,
    ST_W_MRD3  = 5'h0c,
    ST_UPD0    = 5'h0d,
    ST_W_MOD   = 5'h0e,
    ST_ZQ      = 5'h0f,
    ST_W_ZQ    = 5'h10,
    ST_W_DLLK  = 5'h11
  } seq_st_t;

endpackage : dll_seq_pkg

/* seq_timer_if.sv */
`timescale 1ns/1ps
interface seq_timer_if #(parameter int W = 10);
  logic         load;
  logic [W-1:0] value;
  logic         expired;
  modport ctl (output load, output value, input expired);
  modport tmr (input load, input value, output expired);
endinterface : seq_timer_if

/* seq_timer.sv */
`timescale 1ns/1ps
module seq_timer #(
  parameter int W = 10
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Timer control.
  seq_timer_if.tmr t
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_state_t;

  tmr_state_t s_r;
  tmr_state_t s_nxt;

  // ==========================================================
  // Down counter that stands at zero when expired.
  always_comb
  begin
    s_nxt = s_r;
    if (t.load)
      s_nxt.cnt = t.value;
    else if (s_r.cnt != '0)
      s_nxt.cnt = s_r.cnt - W'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign t.expired = (s_r.cnt == '0);

endmodule : seq_timer

/* dll_on_switch.sv */
// Function
// - Start only from idle, termination off first.
// - Wait tCKSRE after entry before clock change.
// - Stable new clock tCKSRX before exit.
// - Hold CKE high until tDLLK after reset.
// - Hold ODT low until tDLLK after reset.
// - After tXS, write MR1 A0 to zero.
// - After tMRD, write MR0 A8 one.
// - After tMRD, write new-frequency mode values.
// - Optional long ZQ only after tMOD.
// - No locked-DLL command before tDLLK.
// - Wait tZQoper when long ZQ was issued.
// - Counts are clock edges, four between writes.
// - Nanoseconds become cycles, rounded up.
`timescale 1ns/1ps
module dll_on_switch
  import dll_seq_pkg::*;
#(
  parameter int XS_CYCLES    = dll_seq_pkg::XS_CYC,
  parameter int DLLK_CYCLES  = dll_seq_pkg::TDLLK_NCK,
  parameter int ZQOPER_CYC   = dll_seq_pkg::TZQOPER_NCK
) (
  // Clock and reset.
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  // User requests.
  input  wire logic                          start,
  input  wire logic                          idle_ok,
  input  wire logic                          zq_en,
  input  wire logic [dll_seq_pkg::ADDR_W-1:0] mr0_val,
  input  wire logic [dll_seq_pkg::ADDR_W-1:0] mr1_val,
  input  wire logic [dll_seq_pkg::ADDR_W-1:0] mr2_val,
  // Clock generator handshake.
  input  wire logic                          clk_stable,
  output logic                               chg_freq,
  // User status.
  output logic                               busy,
  output logic                               done,
  // Memory pins.
  output logic                               cke,
  output logic                               cs_n,
  output logic                               ras_n,
  output logic                               cas_n,
  output logic                               we_n,
  output logic [2:0]                         ba,
  output logic [dll_seq_pkg::ADDR_W-1:0]      addr,
  output logic                               odt
);
  import dll_seq_pkg::*;

  typedef struct packed {
    seq_st_t           st;
    logic              sync1;
    logic              sync2;
    logic              cke;
    logic [3:0]        cmd;
    logic [2:0]        ba;
    logic [ADDR_W-1:0] addr;
    logic              odt;
    logic              busy;
    logic              done;
    logic              chg;
    logic              zq_used;
    logic [TMR_W-1:0]  dllk;
  } seq_state_t;

  localparam seq_state_t S_RST = '{st: ST_IDLE, sync1: 1'b0, sync2: 1'b0, cke: 1'b1,
                                   cmd: CMD_DES, ba: 3'h0, addr: '0, odt: 1'b0,
                                   busy: 1'b0, done: 1'b0, chg: 1'b0, zq_used: 1'b0,
                                   dllk: '0};

  seq_state_t s_r;
  seq_state_t s_nxt;

  seq_timer_if #(.W(TMR_W)) tif ();

  seq_timer #(.W(TMR_W)) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .t       (tif)
  );

  // Timer load value that makes the next command land exactly n edges later, for n of 3 or more.
  function automatic logic [TMR_W-1:0] gap(input int n);
    return (n > 2) ? TMR_W'(n - 2) : '0;
  endfunction : gap

  // ==========================================================
  // Sequence state machine.
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.sync1 = clk_stable;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.cmd   = CMD_NOP;
    s_nxt.ba    = 3'h0;
    s_nxt.addr  = '0;
    s_nxt.odt   = 1'b0;
    s_nxt.done  = 1'b0;
    tif.load    = 1'b0;
    tif.value   = '0;
    if (s_r.dllk != '0)
      s_nxt.dllk = s_r.dllk - TMR_W'(1);
    unique case (s_r.st)
      ST_IDLE:
      begin
        s_nxt.cmd = CMD_DES;
        if (start && idle_ok)
        begin
          s_nxt.st   = ST_SRE;
          s_nxt.busy = 1'b1;
        end
      end
      ST_SRE:
      begin
        s_nxt.cmd = CMD_REF;
        s_nxt.cke = 1'b0;
        tif.load  = 1'b1;
        tif.value = gap(CKSRE_CYC);
        s_nxt.st  = ST_W_CKSRE;
      end
      ST_W_CKSRE:
        if (tif.expired)
          s_nxt.st = ST_W_CLK;
      ST_W_CLK:
      begin
        s_nxt.chg = 1'b1;
        if (s_r.sync2)
        begin
          s_nxt.chg = 1'b0;
          tif.load  = 1'b1;
          tif.value = gap(CKSRX_CYC);
          s_nxt.st  = ST_W_CKSRX;
        end
      end
      ST_W_CKSRX:
        if (!s_r.sync2)
          s_nxt.st = ST_W_CLK;
        else if (tif.expired)
          s_nxt.st = ST_SRX;
      ST_SRX:
      begin
        s_nxt.cke = 1'b1;
        tif.load  = 1'b1;
        tif.value = gap(XS_CYCLES);
        s_nxt.st  = ST_W_XS;
      end
      ST_W_XS:
        if (tif.expired)
          s_nxt.st = ST_DLL_ON;
      ST_DLL_ON:
      begin
        s_nxt.cmd              = CMD_MRS;
        s_nxt.ba               = BA_MR1;
        s_nxt.addr             = mr1_val;
        s_nxt.addr[BIT_DLL_OFF] = 1'b0;
        tif.load               = 1'b1;
        tif.value              = gap(MRD_CYC);
        s_nxt.st               = ST_W_MRD1;
      end
      ST_W_MRD1:
        if (tif.expired)
          s_nxt.st = ST_DLL_RST;
      ST_DLL_RST:
      begin
        s_nxt.cmd              = CMD_MRS;
        s_nxt.ba               = BA_MR0;
        s_nxt.addr             = mr0_val;
        s_nxt.addr[BIT_DLL_RST] = 1'b1;
        s_nxt.dllk             = TMR_W'(DLLK_CYCLES - 1);
        tif.load               = 1'b1;
        tif.value              = gap(MRD_CYC);
        s_nxt.st               = ST_W_MRD2;
      end
      ST_W_MRD2:
        if (tif.expired)
          s_nxt.st = ST_UPD2;
      ST_UPD2:
      begin
        s_nxt.cmd  = CMD_MRS;
        s_nxt.ba   = BA_MR2;
        s_nxt.addr = mr2_val;
        tif.load   = 1'b1;
        tif.value  = gap(MRD_CYC);
        s_nxt.st   = ST_W_MRD3;
      end
      ST_W_MRD3:
        if (tif.expired)
          s_nxt.st = ST_UPD0;
      ST_UPD0:
      begin
        s_nxt.cmd              = CMD_MRS;
        s_nxt.ba               = BA_MR0;
        s_nxt.addr             = mr0_val;
        s_nxt.addr[BIT_DLL_RST] = 1'b0;
        s_nxt.zq_used          = zq_en;
        tif.load               = 1'b1;
        tif.value              = gap(MOD_CYC);
        s_nxt.st               = ST_W_MOD;
      end
      ST_W_MOD:
        if (tif.expired)
          s_nxt.st = s_r.zq_used ? ST_ZQ : ST_W_DLLK;
      ST_ZQ:
      begin
        s_nxt.cmd              = CMD_ZQ;
        s_nxt.addr[BIT_ZQ_LONG] = 1'b1;
        tif.load               = 1'b1;
        tif.value              = gap(ZQOPER_CYC);
        s_nxt.st               = ST_W_ZQ;
      end
      ST_W_ZQ:
        if (tif.expired)
          s_nxt.st = ST_W_DLLK;
      ST_W_DLLK:
        if (s_r.dllk == '0)
        begin
          s_nxt.done = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.st   = ST_IDLE;
        end
      default:
        s_nxt = S_RST;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s_r <= S_RST;
    else
      s_r <= s_nxt;
  end

  assign cke      = s_r.cke;
  assign cs_n     = s_r.cmd[3];
  assign ras_n    = s_r.cmd[2];
  assign cas_n    = s_r.cmd[1];
  assign we_n     = s_r.cmd[0];
  assign ba       = s_r.ba;
  assign addr     = s_r.addr;
  assign odt      = s_r.odt;
  assign busy     = s_r.busy;
  assign done     = s_r.done;
  assign chg_freq = s_r.chg;

  // ==========================================================
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic is_mrs;
  logic in_wait;
  assign is_mrs  = (s_r.cmd == CMD_MRS);
  assign in_wait = s_r.st inside {ST_W_CKSRE, ST_W_CLK, ST_W_CKSRX, ST_W_XS, ST_W_MRD1,
                                  ST_W_MRD2, ST_W_MRD3, ST_W_MOD, ST_W_ZQ, ST_W_DLLK};

  a_busy_odt_low: assert property (busy |-> !odt)
    else $error("ODT not low during switch");
  a_cke_dllk_hold: assert property ($rose(cke) |=> cke until_with done)
    else $error("CKE dropped before DLL lock");
  a_sre_clk_wait: assert property ($fell(cke) |-> !chg_freq [*5])
    else $error("Clock change allowed before tCKSRE");
  a_srx_stable: assert property ($rose(cke) |-> $past(s_r.sync2) && !chg_freq)
    else $error("Self-refresh exit without stable clock");
  a_mrs_spacing: assert property (is_mrs |=> !is_mrs [*3])
    else $error("Mode writes closer than four edges");
  a_dll_enable: assert property (is_mrs && ba == BA_MR1 |-> !addr[BIT_DLL_OFF])
    else $error("MR1 write leaves DLL disabled");
  a_xs_gap: assert property ($rose(cke) |-> !is_mrs [*8])
    else $error("Mode write too soon after exit");
  a_dll_reset: assert property (is_mrs && $past(s_r.st) == ST_DLL_RST
                                |-> ba == BA_MR0 && addr[BIT_DLL_RST])
    else $error("DLL reset write malformed");
  a_zq_after_mod: assert property (s_r.cmd == CMD_ZQ |-> !$past(is_mrs, 1) && !$past(is_mrs, 2)
                                   && addr[BIT_ZQ_LONG])
    else $error("Long ZQ too soon after mode write");
  a_done_locked: assert property ($rose(done) |-> s_r.dllk == '0 && cke)
    else $error("Done before DLL lock time");
  a_wait_nop: assert property (in_wait |=> s_r.cmd == CMD_NOP)
    else $error("Command issued during wait");

  c_start: cover property (s_r.st == ST_IDLE && start && idle_ok);
  c_clk_retry: cover property (s_r.st == ST_W_CKSRX ##1 s_r.st == ST_W_CLK);
  c_done_zq: cover property (s_r.cmd == CMD_ZQ ##[1:1000] done);
  c_done_plain: cover property (done && !s_r.zq_used);

endmodule : dll_on_switch

/* mem_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Memory device model: mode register state and command spacing.
module mem_model
  import dll_seq_pkg::*;
(
  // Clock and reset.
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  // Command pins.
  input  wire logic                          cke,
  input  wire logic                          cs_n,
  input  wire logic                          ras_n,
  input  wire logic                          cas_n,
  input  wire logic                          we_n,
  input  wire logic [2:0]                    ba,
  input  wire logic [dll_seq_pkg::ADDR_W-1:0] addr,
  // Device status.
  output logic                               dll_off,
  output logic [7:0]                         viol
);
  logic [3:0] cmd;
  int         since_mrs;

  assign cmd = {cs_n, ras_n, cas_n, we_n};

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      dll_off   <= 1'b1;
      viol      <= 8'h00;
      since_mrs <= 1000;
    end
    else if (cke && cmd == CMD_MRS)
    begin
      since_mrs <= 1;
      if (since_mrs < MRD_CYC)
        viol <= viol + 8'h01;
      if (ba == BA_MR1)
        dll_off <= addr[BIT_DLL_OFF];
    end
    else
    begin
      since_mrs <= since_mrs + 1;
      if (cmd != CMD_NOP && !cmd[3] && since_mrs < MOD_CYC)
        viol <= viol + 8'h01;
    end
  end
endmodule : mem_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import dll_seq_pkg::*;
  localparam int XS   = 8;
  localparam int DLLK = 20;
  localparam int ZQO  = 20;
  // ==========================================================
  // Bench signals.
  logic              ref_clk    = 1'b0;
  logic              rst_n      = 1'b0;
  logic              start      = 1'b0;
  logic              idle_ok    = 1'b0;
  logic              zq_en      = 1'b0;
  logic              clk_stable = 1'b0;
  logic [ADDR_W-1:0] mr0_val    = 16'h0d70;
  logic [ADDR_W-1:0] mr1_val    = 16'h0045;
  logic [ADDR_W-1:0] mr2_val    = 16'h0018;
  logic              chg_freq, busy, done, cke, cs_n, ras_n, cas_n, we_n, odt, dll_off;
  logic [2:0]        ba;
  logic [ADDR_W-1:0] addr, zq_a;
  logic [7:0]        viol;
  logic              cke_q = 1'b1;
  logic              stb_q = 1'b0;
  int                errors = 0;
  int                num_checks = 0;
  int                cyc = 0;
  int                t_fall, t_rise, t_stab, t_zq, nfall, nzq, nbad, nodt;
  int                m_t[$];
  logic [2:0]        m_ba[$];
  logic [ADDR_W-1:0] m_a[$];

  dll_on_switch #(.XS_CYCLES(XS), .DLLK_CYCLES(DLLK), .ZQOPER_CYC(ZQO)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .start(start), .idle_ok(idle_ok),
    .zq_en(zq_en), .mr0_val(mr0_val), .mr1_val(mr1_val), .mr2_val(mr2_val),
    .clk_stable(clk_stable), .chg_freq(chg_freq), .busy(busy), .done(done),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .odt(odt));

  mem_model u_mem (
    .ref_clk(ref_clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dll_off(dll_off),
    .viol(viol));

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ==========================================================
  // Pin monitor.
  always @(negedge ref_clk)
  begin
    if (cke_q === 1'b1 && cke === 1'b0)
    begin
      t_fall = cyc;
      nfall++;
    end
    if (cke_q === 1'b0 && cke === 1'b1)
      t_rise = cyc;
    if (stb_q === 1'b0 && clk_stable === 1'b1)
      t_stab = cyc;
    if (odt !== 1'b0)
      nodt++;
    case ({cs_n, ras_n, cas_n, we_n})
      CMD_MRS:
      begin
        m_t.push_back(cyc);
        m_ba.push_back(ba);
        m_a.push_back(addr);
      end
      CMD_ZQ:
      begin
        t_zq = cyc;
        zq_a = addr;
        nzq++;
      end
      CMD_NOP, CMD_DES, CMD_REF: ;
      default: nbad++;
    endcase
    cke_q = cke;
    stb_q = clk_stable;
  end

  // ==========================================================
  // Checking and closing.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task summarize;
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task timeout;
    errors++;
    summarize;
  endtask : timeout

  // ==========================================================
  // Scenarios.
  task reset_state;
    check(cke, 1'b1);
    check({cs_n, ras_n, cas_n, we_n}, CMD_DES);
    check(busy, 1'b0);
    check(chg_freq, 1'b0);
  endtask : reset_state

  task refuse;
    @(posedge ref_clk);
    idle_ok <= 1'b0;
    start   <= 1'b1;
    repeat (4) @(negedge ref_clk) check(busy, 1'b0);
    @(posedge ref_clk);
    start <= 1'b0;
  endtask : refuse

  task run_seq(input logic zq, input logic glitch);
    int n;
    int t_done;
    m_t.delete();
    m_ba.delete();
    m_a.delete();
    nfall = 0;
    nzq   = 0;
    nbad  = 0;
    nodt  = 0;
    @(posedge ref_clk);
    start   <= 1'b1;
    idle_ok <= 1'b1;
    zq_en   <= zq;
    @(posedge ref_clk);
    start <= 1'b0;
    for (n = 0; n < 60 && chg_freq !== 1'b1; n++) @(negedge ref_clk);
    if (n == 60)
      timeout;
    check(cyc - t_fall >= CKSRE_CYC, 1'b1);
    check(busy, 1'b1);
    repeat (3) @(posedge ref_clk);
    clk_stable <= 1'b1;
    if (glitch)
    begin
      repeat (4) @(posedge ref_clk);
      clk_stable <= 1'b0;
      repeat (3) @(posedge ref_clk);
      clk_stable <= 1'b1;
    end
    for (n = 0; n < 600 && done !== 1'b1; n++) @(negedge ref_clk);
    if (n == 600)
      timeout;
    t_done = cyc;
    check(busy, 1'b0);
    @(posedge ref_clk);
    clk_stable <= 1'b0;
    check(t_rise - t_stab >= CKSRX_CYC, 1'b1);
    check(nfall, 1);
    check(nodt, 0);
    check(nbad, 0);
    check(m_t.size(), 4);
    if (m_t.size() == 4)
    begin
      check(m_t[0] - t_rise, XS);
      check(m_ba[0], BA_MR1);
      check(m_a[0], mr1_val & 16'hfffe);
      check(m_t[1] - m_t[0], MRD_CYC);
      check(m_ba[1], BA_MR0);
      check(m_a[1], mr0_val | 16'h0100);
      check(m_t[2] - m_t[1], MRD_CYC);
      check(m_ba[2], BA_MR2);
      check(m_a[2], mr2_val);
      check(m_t[3] - m_t[2], MRD_CYC);
      check(m_a[3], mr0_val & 16'hfeff);
      check(m_ba[3], BA_MR0);
      check(t_done - m_t[1] >= DLLK, 1'b1);
    end
    check(nzq, zq);
    if (zq && m_t.size() == 4)
    begin
      check(t_zq - m_t[3], MOD_CYC);
      check(zq_a[BIT_ZQ_LONG], 1'b1);
      check(t_done - t_zq >= ZQO, 1'b1);
    end
    check(viol, 8'h00);
    check(dll_off, 1'b0);
  endtask : run_seq

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge ref_clk);
    reset_state;
    refuse;
    run_seq(1'b1, 1'b0);
    run_seq(1'b0, 1'b1);
    summarize;
  end
endmodule : tb
